// ==== include/swd_regs.vh ====
`ifndef SWD_REGS_VH
`define SWD_REGS_VH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define SWD_OP_ENABLE_CHG   8'h06
`define SWD_OP_DISABLE_CHG  8'h04
`define SWD_OP_WRITE_TO     8'h01
`define SWD_OP_READ_TO      8'h05
`define SWD_OP_TRIP_ARM     8'h03
`define SWD_OP_TRIP_GO      8'h02
`define SWD_TRIP_SET        8'h01
`define SWD_TRIP_RESTORE    8'h03

// ----------------------------------------------------------------------------
// Timeout register layout
// ----------------------------------------------------------------------------
`define SWD_SEL_HI_BIT      4
`define SWD_SEL_LO_BIT      3
`define SWD_TO_RESET        8'h00
`define SWD_TO_MASK         8'h18

// ----------------------------------------------------------------------------
// Times (ms) and clock rate (Hz)
// ----------------------------------------------------------------------------
`define SWD_CLK_HZ          10000000
`define SWD_TO_SEL0_MS      1400
`define SWD_TO_SEL1_MS      600
`define SWD_TO_SEL2_MS      200
`define SWD_PURST_MS        200
`define SWD_NVW_MS          5
`define SWD_MS_CYC(ms)      ((ms) * (`SWD_CLK_HZ / 1000))

`endif

// ==== hdl/swd_supervisor.v ====
// Functional notes
// - All bytes shifted MSB first
// - Sample input on rising serial clock edges
// - Output changes on falling serial clock edges
// - Paused clock keeps shift state intact
// - 8-bit timeout register, select bits 4:3
// - Select codes 1.4s, 600ms, 200ms, off
// - Opcodes 06 set, 04 clear latch
// - Opcode 01 writes, 05 reads register
// - Write ignored unless latch already set
// - Latch clears at power-up and after write
// - Read returns select bits, reserved zero
// - Read during write returns all ones
// - Reset low on low supply or timeout
// - No chip-select activity in period resets
// - Power-up standby, needs select fall, reset
// - Change needs deselect at exact count
// - Chip-select falling edge restarts watchdog
// - Hold reset 200ms after supply recovers
// - Deselected output is high impedance
`include "swd_regs.vh"

module swd_supervisor #(
  parameter integer TO_SEL0_CYC = `SWD_MS_CYC(`SWD_TO_SEL0_MS),
  parameter integer TO_SEL1_CYC = `SWD_MS_CYC(`SWD_TO_SEL1_MS),
  parameter integer TO_SEL2_CYC = `SWD_MS_CYC(`SWD_TO_SEL2_MS),
  parameter integer PURST_CYC   = `SWD_MS_CYC(`SWD_PURST_MS),
  parameter integer NVW_CYC     = `SWD_MS_CYC(`SWD_NVW_MS)
) (
  input  wire       clk,
  input  wire       srst,
  input  wire       chip_select_watchdog_input,
  input  wire       sck,
  input  wire       sdi,
  output reg        sdo,
  output reg        sdo_oe,
  input  wire       trip_program_enable,
  input  wire       supply_low,
  output wire       reset_n_out,
  output wire       reset_n_oe,
  output reg        trip_set_pulse,
  output reg        trip_restore_pulse,
  output reg        nv_write_busy
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  // Synchroniser stages and edge history
  reg  [1:0] cs_sy;
  reg  [1:0] sck_sy;
  reg  [1:0] sdi_sy;
  reg  [1:0] pe_sy;
  reg  [1:0] low_sy;
  reg        cs_d;
  reg        sck_d;

  // Two flops per outside input; second stage is the only reader of the first
  always @(posedge clk) begin
    if (srst) begin
      cs_sy  <= 2'h3;
      sck_sy <= 2'h0;
      sdi_sy <= 2'h0;
      pe_sy  <= 2'h0;
      low_sy <= 2'h3;
      cs_d   <= 1'b1;
      sck_d  <= 1'b0;
    end else begin
      cs_sy  <= {cs_sy[0], chip_select_watchdog_input};
      sck_sy <= {sck_sy[0], sck};
      sdi_sy <= {sdi_sy[0], sdi};
      pe_sy  <= {pe_sy[0], trip_program_enable};
      low_sy <= {low_sy[0], supply_low};
      cs_d   <= cs_sy[1];
      sck_d  <= sck_sy[1];
    end
  end

  // Edge strobes from the synchronised pins; serial clock counts only while selected
  wire cs_n    = cs_sy[1];
  wire cs_fall = cs_d & ~cs_n;
  wire cs_rise = ~cs_d & cs_n;
  wire sck_up  = ~sck_d & sck_sy[1] & ~cs_n;
  wire sck_dn  = sck_d & ~sck_sy[1] & ~cs_n;

  // --------------------------------------------------------------------------
  // Serial shifter and frame decode
  // --------------------------------------------------------------------------
  // Frame capture, command and store state
  reg  [7:0] timeout_reg;
  reg        chg_latch;
  reg        armed;
  reg        seen_fall;
  reg  [4:0] bit_cnt;
  reg  [7:0] shreg;
  reg  [7:0] opcode;
  reg  [7:0] byte1;
  reg  [7:0] byte2;
  reg        latch_at_start;
  reg        rd_active;
  reg  [7:0] rd_shift;
  reg  [7:0] pend_data;
  reg        pend_write;
  reg  [2:0] trip_kind;
  reg  [23:0] nvw_cnt;
  wire [7:0] next_shreg = {shreg[6:0], sdi_sy[1]};  // MSB first

  // Store finishing this cycle; clears the change latch on completion
  wire       nv_done = nv_write_busy & (nvw_cnt <= 24'h000001);

  // Launch kinds for the trip pulses
  localparam [2:0] TK_NONE = 3'h0;
  localparam [2:0] TK_SET  = 3'h1;
  localparam [2:0] TK_RST  = 3'h2;

  // Shift on rising edges only while selected; state holds when sck pauses
  always @(posedge clk) begin
    if (srst) begin
      seen_fall      <= 1'b0;
      bit_cnt        <= 5'h00;
      shreg          <= 8'h00;
      opcode         <= 8'h00;
      byte1          <= 8'h00;
      byte2          <= 8'h00;
      latch_at_start <= 1'b0;
      chg_latch      <= 1'b0;
      armed          <= 1'b0;
      rd_active      <= 1'b0;
      rd_shift       <= 8'h00;
      sdo            <= 1'b0;
      sdo_oe         <= 1'b0;
      pend_data      <= 8'h00;
      pend_write     <= 1'b0;
      trip_kind      <= TK_NONE;
    end else begin
      // Strobes default low each cycle
      pend_write <= 1'b0;
      trip_kind  <= TK_NONE;
      sdo_oe     <= ~cs_n & rd_active;
      // Latch drops when a store completes; a set in the same cycle wins
      if (nv_done) begin
        chg_latch <= 1'b0;
      end
      if (cs_fall) begin
        seen_fall      <= 1'b1;
        bit_cnt        <= 5'h00;
        rd_active      <= 1'b0;
        latch_at_start <= chg_latch;
      end else if (sck_up && seen_fall && bit_cnt != 5'h1f) begin
        shreg   <= next_shreg;
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'h07) begin
          opcode <= next_shreg;
          if (next_shreg == `SWD_OP_ENABLE_CHG) begin
            chg_latch <= 1'b1;
          end else if (next_shreg == `SWD_OP_DISABLE_CHG) begin
            chg_latch <= 1'b0;
          end else if (next_shreg == `SWD_OP_READ_TO) begin
            rd_active <= 1'b1;
            rd_shift  <= nv_write_busy ? 8'hff
                         : (timeout_reg & `SWD_TO_MASK);
          end
        end
        if (bit_cnt == 5'h0f) begin
          byte1 <= next_shreg;
        end
        if (bit_cnt == 5'h17) begin
          byte2 <= next_shreg;
        end
      end else if (sck_dn && rd_active) begin
        // Reply bit moves out on each falling edge
        sdo      <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b1};
      end
      if (cs_rise && seen_fall) begin
        // Deselect ends the frame and any reply
        rd_active <= 1'b0;
        // Write commits only at exactly 16 bits with latch set at start
        if (opcode == `SWD_OP_WRITE_TO && bit_cnt == 5'h10 &&
            latch_at_start && !nv_write_busy) begin
          pend_data  <= shreg & `SWD_TO_MASK;
          pend_write <= 1'b1;
        end
        // Trip frames: first arms, second launches if program enable held
        if (bit_cnt == 5'h18 && pe_sy[1] && byte1 == 8'h00) begin
          if (opcode == `SWD_OP_TRIP_ARM && byte2 == `SWD_TRIP_SET) begin
            armed <= 1'b1;
          end else if (opcode == `SWD_OP_TRIP_GO && armed) begin
            armed <= 1'b0;
            if (byte2 == `SWD_TRIP_SET) begin
              trip_kind <= TK_SET;
            end else if (byte2 == `SWD_TRIP_RESTORE) begin
              trip_kind <= TK_RST;
            end
          end else begin
            armed <= 1'b0;
          end
        end else begin
          armed <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Nonvolatile write cycle and trip pulses
  // --------------------------------------------------------------------------
  // Busy window models the store time; register updates at its end
  always @(posedge clk) begin
    if (srst) begin
      timeout_reg        <= `SWD_TO_RESET;
      nv_write_busy      <= 1'b0;
      nvw_cnt            <= 24'h000000;
      trip_set_pulse     <= 1'b0;
      trip_restore_pulse <= 1'b0;
    end else begin
      // One-cycle launch pulses
      trip_set_pulse     <= (trip_kind == TK_SET);
      trip_restore_pulse <= (trip_kind == TK_RST);
      // Store window countdown
      if (pend_write) begin
        nv_write_busy <= 1'b1;
        nvw_cnt       <= NVW_CYC[23:0];
      end else if (nv_write_busy) begin
        if (nvw_cnt <= 24'h000001) begin
          nv_write_busy <= 1'b0;
          timeout_reg   <= pend_data;
        end else begin
          nvw_cnt <= nvw_cnt - 24'h000001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog and reset generation
  // --------------------------------------------------------------------------
  reg  [23:0] wd_cnt;
  reg  [23:0] hold_cnt;
  reg         wd_fired;
  reg         rst_hold;
  reg  [23:0] wd_limit;
  wire [1:0]  sel = {timeout_reg[`SWD_SEL_HI_BIT], timeout_reg[`SWD_SEL_LO_BIT]};
  wire        wd_on = (sel != 2'h3);

  // Terminal count from the select bits
  always @* begin
    case (sel)
      2'h0:    wd_limit = TO_SEL0_CYC[23:0];
      2'h1:    wd_limit = TO_SEL1_CYC[23:0];
      2'h2:    wd_limit = TO_SEL2_CYC[23:0];
      default: wd_limit = TO_SEL0_CYC[23:0];
    endcase
  end

  // Free-running count restarted by each select falling edge
  always @(posedge clk) begin
    if (srst) begin
      wd_cnt   <= 24'h000000;
      wd_fired <= 1'b0;
    end else if (cs_fall || !wd_on) begin
      wd_cnt   <= 24'h000000;
      wd_fired <= 1'b0;
    end else if (rst_hold) begin
      wd_cnt   <= 24'h000000;
      wd_fired <= 1'b0;
    end else if (wd_cnt >= wd_limit - 24'h000001) begin
      wd_fired <= 1'b1;
      wd_cnt   <= 24'h000000;
    end else begin
      wd_cnt   <= wd_cnt + 24'h000001;
      wd_fired <= 1'b0;
    end
  end

  // Low supply or watchdog expiry restarts the hold-off period
  always @(posedge clk) begin
    if (srst) begin
      rst_hold <= 1'b1;
      hold_cnt <= PURST_CYC[23:0];
    end else if (low_sy[1] || wd_fired) begin
      rst_hold <= 1'b1;
      hold_cnt <= PURST_CYC[23:0];
    end else if (hold_cnt > 24'h000001) begin
      hold_cnt <= hold_cnt - 24'h000001;
    end else begin
      hold_cnt <= 24'h000000;
      rst_hold <= 1'b0;
    end
  end

  // Open drain: drive low only
  assign reset_n_out = 1'b0;
  assign reset_n_oe  = rst_hold;

endmodule // swd_supervisor

// ==== tb/swd_supervisor_checker.sv ====
// ----------------------------------------
// Port checker for the supervisor
// ----------------------------------------
module swd_supervisor_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic chip_select_watchdog_input,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic trip_program_enable,
  input wire logic supply_low,
  input wire logic reset_n_out,
  input wire logic reset_n_oe,
  input wire logic trip_set_pulse,
  input wire logic trip_restore_pulse,
  input wire logic nv_write_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Output stays off while deselected
  chk_idle_hiz: assert property (chip_select_watchdog_input [*6] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  chk_low_supply: assert property (supply_low [*6] |-> reset_n_oe)
    else $error("reset not asserted on low supply");
  chk_drain_low: assert property (reset_n_out == 1'b0)
    else $error("reset pin driven high");
  chk_por_hold: assert property ($fell(srst) |-> reset_n_oe [*8])
    else $error("power-up reset released early");
  chk_sdo_fall: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck)
    else $error("sdo changed while sck high");
  chk_store_len: assert property ($rose(nv_write_busy) |-> nv_write_busy [*8])
    else $error("store shorter than expected");
  chk_store_cs: assert property ($rose(nv_write_busy) |-> chip_select_watchdog_input)
    else $error("store began while selected");
  chk_trip_pe: assert property (trip_set_pulse || trip_restore_pulse |-> trip_program_enable)
    else $error("trip launched without enable");
  chk_pulse_one: assert property (trip_set_pulse |=> !trip_set_pulse)
    else $error("set pulse wider than one cycle");
  chk_pulse_excl: assert property (!(trip_set_pulse && trip_restore_pulse))
    else $error("set and restore together");
  chk_hold_min: assert property ($rose(reset_n_oe) |-> reset_n_oe [*8])
    else $error("reset hold shorter than expected");
endmodule // swd_supervisor_checker

bind swd_supervisor swd_supervisor_checker u_chk (
  .clk(clk), .srst(srst), .chip_select_watchdog_input(chip_select_watchdog_input),
  .sck(sck), .sdo(sdo), .sdo_oe(sdo_oe), .trip_program_enable(trip_program_enable),
  .supply_low(supply_low), .reset_n_out(reset_n_out), .reset_n_oe(reset_n_oe),
  .trip_set_pulse(trip_set_pulse), .trip_restore_pulse(trip_restore_pulse),
  .nv_write_busy(nv_write_busy)
);

// ==== tb/swd_spi_master.sv ====
// ----------------------------------------
// Mode-0 serial master model
// ----------------------------------------
module swd_spi_master (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      cs_n,
  output logic      sck,
  output logic      sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Extra low-clock pause inside a frame, in clock cycles
  int pause_len = 0;
  // Idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One frame, MSB first, reply taken at rising edges
  task automatic xfer(input logic [23:0] d, input int n, output logic [7:0] rd);
    cs_n = 1'b0;
    gap(6);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = d[i];
      gap(4);
      sck = 1'b1;
      // Released output shows the inverse of its last level
      rd = {rd[6:0], sdo_oe ? sdo : ~sdo};
      gap(4);
      sck = 1'b0;
      if (i == 4 && pause_len > 0) begin
        gap(pause_len);
      end
    end
    gap(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    gap(8);
  endtask
endmodule // swd_spi_master

// ==== tb/test_spi_watchdog_supervisor.sv ====
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_spi_watchdog_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk;
  logic       srst;
  logic       pe;
  logic       low;
  logic [7:0] rd;
  wire        cs_n;
  wire        sck;
  wire        sdi;
  wire        sdo;
  wire        sdo_oe;
  wire        rst_n;
  wire        rst_oe;
  wire        set_p;
  wire        rest_p;
  wire        busy;
  int         n_fail = 0;
  int         tests_run = 0;
  int         n_set = 0;
  int         n_rest = 0;
  // Start-up levels: clock low, reset held, enable and low supply off
  initial begin
    clk  = 1'b0;
    srst = 1'b1;
    pe   = 1'b0;
    low  = 1'b0;
  end
  always #50 clk = ~clk;
  swd_supervisor #(.TO_SEL0_CYC(2000), .TO_SEL1_CYC(1000), .TO_SEL2_CYC(500),
    .PURST_CYC(80), .NVW_CYC(400)) DUT (
    .clk(clk), .srst(srst), .chip_select_watchdog_input(cs_n), .sck(sck), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .trip_program_enable(pe), .supply_low(low),
    .reset_n_out(rst_n), .reset_n_oe(rst_oe), .trip_set_pulse(set_p),
    .trip_restore_pulse(rest_p), .nv_write_busy(busy));
  swd_spi_master m (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck),
    .sdi(sdi));
  // Count launch pulses mid-cycle, where they are settled
  always @(negedge clk) begin
    n_set += int'(set_p === 1'b1);
    n_rest += int'(rest_p === 1'b1);
  end
  task automatic op(input logic [23:0] d, input int n);
    m.xfer(d, n, rd);
  endtask
  task automatic wr(input logic [7:0] v);
    op({8'h00, 8'h01, v}, 16);
  endtask
  task automatic rchk(input logic [7:0] e);
    op(24'h000500, 16);
    `CHK("timeout reg", e, rd)
  endtask
  task automatic conclude;
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog on the run itself
  initial begin
    m.gap(20000);
    n_fail++;
    conclude;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    m.gap(60);
    `CHK("por hold", 1'b1, rst_oe)
    m.gap(40);
    `CHK("por end", 1'b0, rst_oe)
    rchk(8'h00);
    wr(8'h18);
    rchk(8'h00);
    op(24'h06, 8);
    op(24'h04, 8);
    wr(8'h18);
    rchk(8'h00);
    op(24'h06, 8);
    op({7'h00, 8'h01, 8'h18, 1'b0}, 17);
    rchk(8'h00);
    op(24'h06, 8);
    wr(8'hff);
    `CHK("store busy", 1'b1, busy)
    rchk(8'hff);
    m.gap(400);
    rchk(8'h18);
    wr(8'h00);
    rchk(8'h18);
    m.pause_len = 300;
    op(24'h000500, 16);
    `CHK("paused read", 8'h18, rd)
    m.pause_len = 0;
    m.gap(2500);
    `CHK("wd off", 1'b0, rst_oe)
    op(24'h06, 8);
    wr(8'h10);
    m.gap(450);
    op(24'h0, 0);
    m.gap(400);
    op(24'h0, 0);
    m.gap(400);
    `CHK("kick", 1'b0, rst_oe)
    m.gap(150);
    `CHK("bite", 1'b1, rst_oe)
    m.gap(100);
    low = 1'b1;
    m.gap(10);
    `CHK("low supply", 1'b1, rst_oe)
    low = 1'b0;
    m.gap(60);
    `CHK("supply hold", 1'b1, rst_oe)
    m.gap(40);
    `CHK("supply end", 1'b0, rst_oe)
    pe = 1'b1;
    op(24'h030001, 24);
    op(24'h020003, 24);
    op(24'h030001, 24);
    op(24'h020001, 24);
    pe = 1'b0;
    `CHK("restore", 1, n_rest)
    `CHK("set", 1, n_set)
    op(24'h030001, 24);
    op(24'h020001, 24);
    `CHK("no enable", 1, n_set)
    op(24'h06, 8);
    wr(8'h08);
    m.gap(250);
    op(24'h0, 0);
    m.gap(800);
    `CHK("mid no bite", 1'b0, rst_oe)
    m.gap(250);
    `CHK("mid bite", 1'b1, rst_oe)
    conclude;
  end
endmodule // test_spi_watchdog_supervisor
